// File: inc/epbc_consts.svh
// constants for the external program bus configuration block
`ifndef EPBC_CONSTS_SVH
`define EPBC_CONSTS_SVH
`define EPBC_CFG_WAIT_BIT      7
`define EPBC_CFG_BW_BIT        6
`define EPBC_CFG_EMB_HI        5
`define EPBC_CFG_EMB_LO        4
`define EPBC_CFG_SHIFT_BIT     3
`define EPBC_CFG_MASK          8'hf8
`define EPBC_CFG_POR           8'hf8
`define EPBC_EMB_MC            2'h3
`define EPBC_EMB_A12           2'h2
`define EPBC_EMB_A16           2'h1
`define EPBC_EMB_A20           2'h0
`define EPBC_AW_NONE           5'h00
`define EPBC_AW_A12            5'h0c
`define EPBC_AW_A16            5'h10
`define EPBC_AW_A20            5'h14
`define EPBC_MC_RELEASE_BIT    7
`define EPBC_MC_WAIT_HI        5
`define EPBC_MC_WAIT_LO        4
`define EPBC_MC_MASK           8'hb0
`define EPBC_MC_RESET          8'h00
`define EPBC_REG_CFG           4'h0
`define EPBC_REG_MEMCTL        4'h1
`define EPBC_REG_STATUS        4'h2
`define EPBC_ST_BUSY           0
`define EPBC_ST_CFG_VALID      1
`define EPBC_ST_EXT_LAST       2
`define EPBC_SPACE_BYTES       22'h20_0000
`define EPBC_FLASH_BYTES_DEF   22'h01_0000
`define EPBC_SYNC_LAT          2
`define EPBC_CAP_DELAY         2'h2
`define EPBC_LINES             20
`define EPBC_AD_LINES          16
`define EPBC_DATA8_LINES       8
`define EPBC_DATA16_LINES      16
`define EPBC_NARROW_MASK       16'h0fff
`define EPBC_FULL_MASK         16'hffff
`endif

// File: inc/epbc_pkg.sv
// types shared by the external program bus configuration block
`default_nettype none
package epbc_pkg;
  typedef enum logic [2:0] {
    EPBC_IDLE      = 3'h0,
    EPBC_ADDR      = 3'h1,
    EPBC_WAIT      = 3'h3,
    EPBC_DATA      = 3'h2,
    EPBC_DONE      = 3'h6,
    EPBC_FLASH     = 3'h4,
    EPBC_FLASH_CAP = 3'h5
  } epbc_state_e;
  typedef logic [20:0] epbc_pc_t;
endpackage
`default_nettype wire

// File: hw/epbc_addr_map.sv
// fetch address decode, shifting and address line ownership
`timescale 1ns/100ps
`default_nettype none
`include "epbc_consts.svh"
module epbc_addr_map #(
  parameter logic [21:0] FLASH_BYTES = `EPBC_FLASH_BYTES_DEF
) (
  // fetch address
  input  wire epbc_pkg::epbc_pc_t pc,
  // latched configuration
  input  wire logic [1:0]         emb,
  input  wire logic               shift_en,
  // decisions
  output logic                    internal,
  output logic                    zero_word,
  output epbc_pkg::epbc_pc_t      bus_addr,
  output logic [`EPBC_LINES-1:0]  own_mask
);
  logic [21:0] pc_wide;
  logic [21:0] pc_shift;
  logic [4:0]  width;

  // 21-bit byte address spans the whole 2 Mbyte space
  assign pc_wide   = {1'b0, pc};
  assign pc_shift  = pc_wide - FLASH_BYTES;
  assign internal  = pc_wide < FLASH_BYTES;
  assign zero_word = ~internal & (emb == `EPBC_EMB_MC);
  assign bus_addr  = shift_en ? pc_shift[20:0] : pc;
  assign width     = (emb == `EPBC_EMB_A20) ? `EPBC_AW_A20 :
                     (emb == `EPBC_EMB_A16) ? `EPBC_AW_A16 :
                     (emb == `EPBC_EMB_A12) ? `EPBC_AW_A12 : `EPBC_AW_NONE;

  // lines above the selected width belong to general i/o
  for (genvar i = 0; i < `EPBC_LINES; i++) begin : g_own
    assign own_mask[i] = (5'(i) < width);
  end
endmodule
`default_nettype wire

// File: hw/epbc_wait_ctr.sv
// down counter for bus wait and input sync latency
`timescale 1ns/100ps
`default_nettype none
module epbc_wait_ctr #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // status
  output logic              expired
);
  logic [W-1:0] cnt_r;

  if (W < 1) begin : g_chk
    $error("epbc_wait_ctr: W must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = ~load & (cnt_r == '0);
endmodule
`default_nettype wire

// File: hw/epbc_top.sv
// external program bus: configuration capture, fetch routing and bus sequencing
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "epbc_consts.svh"
module epbc_top #(
  parameter logic [21:0] FLASH_BYTES = `EPBC_FLASH_BYTES_DEF,
  parameter int          WAIT_W      = 4
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // programmed configuration byte
  input  wire logic [7:0]  CFG_STRAP,
  // register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // instruction fetch port
  input  wire logic        FETCH_REQ,
  input  wire logic [20:0] FETCH_PC,
  input  wire logic [1:0]  FETCH_BYTE_EN,
  output logic             FETCH_BUSY,
  output logic             FETCH_VALID,
  output logic      [15:0] FETCH_DATA,
  // internal flash
  output logic             FLASH_RD,
  output logic      [20:0] FLASH_ADDR,
  input  wire logic [15:0] FLASH_DATA,
  // external bus pins
  input  wire logic [15:0] AD_I,
  output logic      [15:0] AD_O,
  output logic      [15:0] AD_OE_N,
  output logic      [3:0]  AH_O,
  output logic      [3:0]  AH_OE_N,
  output logic             ALE,
  output logic             OE_N,
  output logic             BYTE_ADDR_LSB,
  output logic             UPPER_BYTE_SEL_N,
  output logic             LOWER_BYTE_SEL_N,
  output logic      [19:0] LINE_IO_FREE
);
  if (FLASH_BYTES == 22'h0 || FLASH_BYTES > `EPBC_SPACE_BYTES || FLASH_BYTES[0]) begin : g_chk_flash
    $error("epbc_top: FLASH_BYTES must be even, nonzero and within the program space");
  end
  if (WAIT_W < 3) begin : g_chk_wait
    $error("epbc_top: WAIT_W too small for wait states plus sync latency");
  end

  // configuration capture
  logic [7:0]  strap_s1_r;
  logic [7:0]  strap_s2_r;
  logic [1:0]  cap_cnt_r;
  logic        cfg_valid_r;
  logic [7:0]  cfg_r;
  logic        cap_fire;
  // register file
  logic [7:0]  memctl_r;
  logic [7:0]  status_w;
  logic [7:0]  rd_mux;
  logic        wr_memctl;
  // decoded fields
  logic        wait_dis;
  logic        bw16;
  logic [1:0]  emb;
  logic        shift_en;
  logic        bus_release;
  logic        aw20;
  logic        narrow16;
  logic [1:0]  wait_states;
  // fetch sequencing
  epbc_pkg::epbc_state_e state_r;
  epbc_pkg::epbc_state_e state_nxt;
  logic        accept;
  logic        map_internal;
  logic        map_zero;
  epbc_pkg::epbc_pc_t map_addr;
  logic [`EPBC_LINES-1:0] own_mask;
  epbc_pkg::epbc_pc_t baddr_r;
  logic [1:0]  be_r;
  logic        byte_r;
  logic        ext_last_r;
  logic [15:0] data_r;
  logic        ctr_load;
  logic        ctr_expired;
  logic [WAIT_W-1:0] ctr_val;
  // external data input synchroniser
  logic [15:0] ad_s1_r;
  logic [15:0] ad_s2_r;
  logic [15:0] ext_word;
  logic [15:0] lane_mask;
  // pin drive
  logic        addr_phase;
  logic        data_phase;
  logic        access_nxt;
  logic [`EPBC_LINES-1:0] addr_only;
  logic [`EPBC_LINES-1:0] drive_nxt;
  logic [`EPBC_LINES-1:0] line_oe_n_r;
  logic [`EPBC_LINES-1:0] io_free_r;
  logic        busy_r;
  logic        valid_r;
  logic        flash_rd_r;
  logic        ale_r;
  logic        oe_n_r;
  logic        ba0_r;
  logic        ub_n_r;
  logic        lb_n_r;
  logic [7:0]  rdata_r;

  // strap passes two flops, then is caught once after release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1_r <= `EPBC_CFG_POR;
      strap_s2_r <= `EPBC_CFG_POR;
    end else begin
      strap_s1_r <= CFG_STRAP;
      strap_s2_r <= strap_s1_r;
    end
  end

  assign cap_fire = ~cfg_valid_r & (cap_cnt_r == `EPBC_CAP_DELAY);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_cnt_r   <= 2'h0;
      cfg_valid_r <= 1'b0;
      cfg_r       <= `EPBC_CFG_POR;
    end else if (cap_fire) begin
      cfg_valid_r <= 1'b1;
      cfg_r       <= strap_s2_r & `EPBC_CFG_MASK;
    end else if (~cfg_valid_r) begin
      cap_cnt_r   <= cap_cnt_r + 2'h1;
    end
  end

  assign wait_dis    = cfg_r[`EPBC_CFG_WAIT_BIT];
  assign bw16        = cfg_r[`EPBC_CFG_BW_BIT];
  assign emb         = cfg_r[`EPBC_CFG_EMB_HI:`EPBC_CFG_EMB_LO];
  assign shift_en    = cfg_r[`EPBC_CFG_SHIFT_BIT];
  assign aw20        = (emb == `EPBC_EMB_A20);
  assign narrow16    = bw16 & (emb == `EPBC_EMB_A12);
  assign bus_release = memctl_r[`EPBC_MC_RELEASE_BIT];
  assign wait_states = wait_dis ? 2'h0 : memctl_r[`EPBC_MC_WAIT_HI:`EPBC_MC_WAIT_LO];

  // configuration register has no write path; only memory control is writable
  assign wr_memctl = REG_WR & (REG_ADDR == `EPBC_REG_MEMCTL);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      memctl_r <= `EPBC_MC_RESET;
    end else if (wr_memctl) begin
      memctl_r <= REG_WDATA & `EPBC_MC_MASK;
    end
  end

  always_comb begin
    status_w = 8'h00;
    status_w[`EPBC_ST_BUSY]      = busy_r;
    status_w[`EPBC_ST_CFG_VALID] = cfg_valid_r;
    status_w[`EPBC_ST_EXT_LAST]  = ext_last_r;
  end

  assign rd_mux = (REG_ADDR == `EPBC_REG_CFG)    ? cfg_r :
                  (REG_ADDR == `EPBC_REG_MEMCTL) ? memctl_r :
                  (REG_ADDR == `EPBC_REG_STATUS) ? status_w : 8'h00;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= REG_RD ? rd_mux : 8'h00;
    end
  end

  epbc_addr_map #(
    .FLASH_BYTES (FLASH_BYTES)
  ) u_map (
    .pc        (FETCH_PC),
    .emb       (emb),
    .shift_en  (shift_en),
    .internal  (map_internal),
    .zero_word (map_zero),
    .bus_addr  (map_addr),
    .own_mask  (own_mask)
  );

  assign accept   = FETCH_REQ & cfg_valid_r & (state_r == epbc_pkg::EPBC_IDLE);
  assign ctr_load = (state_r == epbc_pkg::EPBC_ADDR);
  assign ctr_val  = WAIT_W'(wait_states) + WAIT_W'(`EPBC_SYNC_LAT);

  epbc_wait_ctr #(
    .W (WAIT_W)
  ) u_wait (
    .clk      (CLK),
    .rst_n    (RST_N),
    .load     (ctr_load),
    .load_val (ctr_val),
    .expired  (ctr_expired)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      epbc_pkg::EPBC_IDLE: begin
        if (accept) begin
          if (map_zero) begin
            state_nxt = epbc_pkg::EPBC_DONE;
          end else if (map_internal) begin
            state_nxt = epbc_pkg::EPBC_FLASH;
          end else begin
            state_nxt = epbc_pkg::EPBC_ADDR;
          end
        end
      end
      epbc_pkg::EPBC_FLASH:     state_nxt = epbc_pkg::EPBC_FLASH_CAP;
      epbc_pkg::EPBC_FLASH_CAP: state_nxt = epbc_pkg::EPBC_DONE;
      epbc_pkg::EPBC_ADDR:      state_nxt = epbc_pkg::EPBC_WAIT;
      epbc_pkg::EPBC_WAIT: begin
        if (ctr_expired) begin
          state_nxt = epbc_pkg::EPBC_DATA;
        end
      end
      epbc_pkg::EPBC_DATA: begin
        // 8-bit bus fetches the word as two bytes
        if (~bw16 & ~byte_r) begin
          state_nxt = epbc_pkg::EPBC_ADDR;
        end else begin
          state_nxt = epbc_pkg::EPBC_DONE;
        end
      end
      epbc_pkg::EPBC_DONE:      state_nxt = epbc_pkg::EPBC_IDLE;
      default:                  state_nxt = epbc_pkg::EPBC_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= epbc_pkg::EPBC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      baddr_r    <= '0;
      be_r       <= 2'h0;
      ext_last_r <= 1'b0;
    end else if (accept) begin
      baddr_r    <= map_internal ? FETCH_PC : map_addr;
      be_r       <= FETCH_BYTE_EN;
      ext_last_r <= ~map_internal & ~map_zero;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      byte_r <= 1'b0;
    end else if (accept) begin
      byte_r <= 1'b0;
    end else if (state_r == epbc_pkg::EPBC_DATA) begin
      byte_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ad_s1_r <= 16'h0000;
      ad_s2_r <= 16'h0000;
    end else begin
      ad_s1_r <= AD_I;
      ad_s2_r <= ad_s1_r;
    end
  end

  assign lane_mask = {{8{be_r[1]}}, {8{be_r[0]}}};
  assign ext_word  = ad_s2_r & lane_mask & (narrow16 ? `EPBC_NARROW_MASK : `EPBC_FULL_MASK);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_r <= 16'h0000;
    end else if (accept) begin
      data_r <= 16'h0000;
    end else if (state_r == epbc_pkg::EPBC_FLASH_CAP) begin
      data_r <= FLASH_DATA;
    end else if (state_r == epbc_pkg::EPBC_DATA && bw16) begin
      data_r <= ext_word;
    end else if (state_r == epbc_pkg::EPBC_DATA && !byte_r) begin
      data_r[7:0] <= ad_s2_r[7:0];
    end else if (state_r == epbc_pkg::EPBC_DATA) begin
      data_r[15:8] <= ad_s2_r[7:0];
    end
  end

  // pins carry address in the address phase and turn round for data
  assign addr_phase = (state_nxt == epbc_pkg::EPBC_ADDR);
  assign data_phase = (state_nxt == epbc_pkg::EPBC_WAIT) | (state_nxt == epbc_pkg::EPBC_DATA);
  assign access_nxt = addr_phase | data_phase;

  for (genvar i = 0; i < `EPBC_LINES; i++) begin : g_line
    assign addr_only[i] = bw16 ? (i >= `EPBC_DATA16_LINES) : (i >= `EPBC_DATA8_LINES);
    // owned data lines multiplex address then data, owned lines above the bus width hold the address; freed lines never drive
    assign drive_nxt[i] = own_mask[i] &
                          (addr_phase | (data_phase & addr_only[i]) | (~access_nxt & ~bus_release));
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_oe_n_r <= '1;
      io_free_r   <= '1;
      busy_r      <= 1'b1;
      valid_r     <= 1'b0;
      flash_rd_r  <= 1'b0;
      ale_r       <= 1'b0;
      oe_n_r      <= 1'b1;
    end else begin
      line_oe_n_r <= ~drive_nxt;
      io_free_r   <= ~own_mask;
      busy_r      <= (state_nxt != epbc_pkg::EPBC_IDLE) | ~(cfg_valid_r | cap_fire);
      valid_r     <= (state_nxt == epbc_pkg::EPBC_DONE);
      flash_rd_r  <= (state_nxt == epbc_pkg::EPBC_FLASH);
      ale_r       <= addr_phase;
      oe_n_r      <= ~data_phase;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ba0_r  <= 1'b0;
      ub_n_r <= 1'b1;
      lb_n_r <= 1'b1;
    end else begin
      ba0_r  <= access_nxt & (bw16 ? (aw20 & (accept ? map_addr[0] : baddr_r[0])) :
                                     ((byte_r & ~accept) | (state_r == epbc_pkg::EPBC_DATA)));
      ub_n_r <= ~(access_nxt & bw16 & (accept ? FETCH_BYTE_EN[1] : be_r[1]));
      lb_n_r <= ~(access_nxt & bw16 & (accept ? FETCH_BYTE_EN[0] : be_r[0]));
    end
  end

  assign REG_RDATA        = rdata_r;
  assign FETCH_BUSY       = busy_r;
  assign FETCH_VALID      = valid_r;
  assign FETCH_DATA       = data_r;
  assign FLASH_RD         = flash_rd_r;
  assign FLASH_ADDR       = baddr_r;
  assign AD_O             = baddr_r[`EPBC_AD_LINES:1];
  assign AH_O             = baddr_r[`EPBC_LINES:`EPBC_AD_LINES+1];
  assign AD_OE_N          = line_oe_n_r[`EPBC_AD_LINES-1:0];
  assign AH_OE_N          = line_oe_n_r[`EPBC_LINES-1:`EPBC_AD_LINES];
  assign ALE              = ale_r;
  assign OE_N             = oe_n_r;
  assign BYTE_ADDR_LSB    = ba0_r;
  assign UPPER_BYTE_SEL_N = ub_n_r;
  assign LOWER_BYTE_SEL_N = lb_n_r;
  assign LINE_IO_FREE     = io_free_r;
endmodule
`default_nettype wire

// File: tb/epbc_props.sv
// assertions on the external program bus block ports
`timescale 1ns/100ps
`default_nettype none
module epbc_props #(
  parameter logic [21:0] FLASH_BYTES = 22'h01_0000
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // configuration and registers
  input wire logic [7:0]  CFG_STRAP,
  input wire logic [3:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  // fetch side
  input wire logic        FETCH_REQ,
  input wire logic [20:0] FETCH_PC,
  input wire logic [1:0]  FETCH_BYTE_EN,
  input wire logic        FETCH_BUSY,
  input wire logic        FETCH_VALID,
  input wire logic [15:0] FETCH_DATA,
  input wire logic        FLASH_RD,
  input wire logic [20:0] FLASH_ADDR,
  // bus pins
  input wire logic [15:0] AD_O,
  input wire logic [15:0] AD_OE_N,
  input wire logic [3:0]  AH_O,
  input wire logic [3:0]  AH_OE_N,
  input wire logic        ALE,
  input wire logic        OE_N,
  input wire logic        BYTE_ADDR_LSB,
  input wire logic        UPPER_BYTE_SEL_N,
  input wire logic        LOWER_BYTE_SEL_N,
  input wire logic [19:0] LINE_IO_FREE
);
  logic [20:0] pc_r;
  logic [1:0]  be_r;
  logic [1:0]  wait_r;
  logic [4:0]  low_r;
  logic        cap_r;
  wire  [1:0]  mode  = CFG_STRAP[5:4];
  wire         bw16  = CFG_STRAP[6];
  wire         take  = FETCH_REQ && !FETCH_BUSY;
  wire         above = {1'b0, FETCH_PC} >= FLASH_BYTES;
  wire  [20:0] ea    = CFG_STRAP[3] ? pc_r - FLASH_BYTES[20:0] : pc_r;
  wire  [4:0]  nwait = CFG_STRAP[7] ? 5'h00 : {3'h0, wait_r};
  wire  [19:0] own_n = mode == 2'h3 ? 20'hfffff : mode == 2'h2 ? 20'hff000 : mode == 2'h1 ? 20'hf0000 : 20'h00000;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_r   <= 21'h0;
      be_r   <= 2'h0;
      wait_r <= 2'h0;
      low_r  <= 5'h00;
      cap_r  <= 1'b0;
    end else begin
      if (take) begin
        pc_r <= FETCH_PC;
        be_r <= FETCH_BYTE_EN;
      end
      if (REG_WR && REG_ADDR == 4'h1) begin
        wait_r <= REG_WDATA[5:4];
      end
      low_r <= OE_N ? 5'h00 : low_r + 5'h01;
      cap_r <= cap_r | !FETCH_BUSY;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_zero;
    take && mode == 2'h3 && above;
  endsequence
  sequence s_ext;
    take && mode != 2'h3 && above;
  endsequence
  sequence s_hi_byte;
    ALE && BYTE_ADDR_LSB;
  endsequence
  zero_word_a: assert property (s_zero |=> FETCH_VALID && FETCH_DATA == 16'h0000)
    else $error("zero word missing");
  flash_route_a: assert property (take && !above |=> FLASH_RD && FLASH_ADDR == pc_r && !ALE)
    else $error("flash fetch misrouted");
  ext_route_a: assert property (s_ext |=> ALE && !FLASH_RD)
    else $error("external fetch misrouted");
  bus_addr_a: assert property (ALE |-> (({AH_O, AD_O} ^ ea[20:1]) & ~{AH_OE_N, AD_OE_N}) == 20'h0)
    else $error("bus address wrong");
  line_own_a: assert property (ALE |-> {AH_OE_N, AD_OE_N} == own_n)
    else $error("address lines owned wrongly");
  free_lines_a: assert property (FETCH_VALID |-> LINE_IO_FREE == own_n && (LINE_IO_FREE & ~{AH_OE_N, AD_OE_N}) == 20'h0)
    else $error("freed line driven");
  wait_len_a: assert property ($rose(OE_N) |-> low_r == nwait + 5'h04)
    else $error("wait length wrong");
  upper12_a: assert property (FETCH_VALID && mode == 2'h2 && bw16 |-> FETCH_DATA[15:12] == 4'h0)
    else $error("upper nibble not cleared");
  lsb20_a: assert property (ALE && mode == 2'h0 && bw16 |-> BYTE_ADDR_LSB == ea[0])
    else $error("byte address lsb wrong");
  byte_pair_a: assert property (ALE && !bw16 && !BYTE_ADDR_LSB |-> ##[2:40] s_hi_byte)
    else $error("second byte cycle missing");
  byte_sel_a: assert property (ALE && bw16 |-> UPPER_BYTE_SEL_N == !be_r[1] && LOWER_BYTE_SEL_N == !be_r[0])
    else $error("byte selects wrong");
  mux_phase_a: assert property (!OE_N |-> AD_OE_N[7:0] == 8'hff && !ALE)
    else $error("data lines driven in read");
  cfg_fixed_a: assert property (REG_RD && REG_ADDR == 4'h0 && cap_r |=> REG_RDATA == (CFG_STRAP & 8'hf8))
    else $error("config readback wrong");
endmodule
`default_nettype wire

// File: tb/epbc_mem_model.sv
// external memory with address latch glue on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module epbc_mem_model (
  // clock
  input  wire logic        clk,
  // bus from the device
  input  wire logic [15:0] ad_o,
  input  wire logic [15:0] ad_oe_n,
  input  wire logic        ale,
  input  wire logic        oe_n,
  input  wire logic        lsb,
  // resolved bus lines
  output logic      [15:0] ad_i
);
  logic [15:0] adr_r  = 16'h0000;
  logic        lsb_r  = 1'b0;
  logic [15:0] last_r = 16'h0000;
  wire  [15:0] mem_d;
  // glue latches the address phase of the shared lines
  always @(posedge clk) begin
    if (ale) begin
      adr_r <= ad_o;
      lsb_r <= lsb;
    end
    last_r <= ad_i;
  end
  // contents follow the address; a released bus shows inverted history
  assign mem_d = oe_n ? ~last_r : adr_r ^ 16'ha5c3 ^ {16{lsb_r}};
  assign ad_i  = (~ad_oe_n & ad_o) | (ad_oe_n & mem_d);
endmodule
`default_nettype wire

// File: tb/test_epbc_top.sv
// self-checking bench for the external program bus block
`timescale 1ns/100ps
`default_nettype none
module test_epbc_top;
  localparam logic [21:0] FLASH_BYTES = 22'h01_0000;
  localparam logic [20:0] F = FLASH_BYTES[20:0];
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  cfg = 8'hf8;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        f_req = 1'b0;
  logic [20:0] f_pc = 21'h0;
  logic [1:0]  f_be = 2'h3;
  logic [7:0]  reg_rdata;
  logic        f_busy;
  logic        f_valid;
  logic [15:0] f_data;
  logic        fl_rd;
  logic [20:0] fl_addr;
  logic [15:0] ad_i;
  logic [15:0] ad_o;
  logic [15:0] ad_oe_n;
  logic [3:0]  ah_o;
  logic [3:0]  ah_oe_n;
  logic        ale;
  logic        oe_n;
  logic        lsb;
  logic [19:0] io_free;
  wire  [15:0] fl_data = fl_addr[16:1] ^ 16'h1234;
  int          errors = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  epbc_top #(.FLASH_BYTES(FLASH_BYTES)) epbc_top_i (
    .CLK(clk), .RST_N(rst_n), .CFG_STRAP(cfg), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FETCH_REQ(f_req), .FETCH_PC(f_pc),
    .FETCH_BYTE_EN(f_be), .FETCH_BUSY(f_busy), .FETCH_VALID(f_valid), .FETCH_DATA(f_data),
    .FLASH_RD(fl_rd), .FLASH_ADDR(fl_addr), .FLASH_DATA(fl_data), .AD_I(ad_i), .AD_O(ad_o),
    .AD_OE_N(ad_oe_n), .AH_O(ah_o), .AH_OE_N(ah_oe_n), .ALE(ale), .OE_N(oe_n), .BYTE_ADDR_LSB(lsb),
    .UPPER_BYTE_SEL_N(), .LOWER_BYTE_SEL_N(), .LINE_IO_FREE(io_free));
  epbc_mem_model epbc_mem_model_i (.clk(clk), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .ale(ale), .oe_n(oe_n),
    .lsb(lsb), .ad_i(ad_i));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(20'(reg_rdata), 20'(exp), what);
  endtask
  task automatic boot(input logic [7:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg   <= s;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8 && f_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(20'(f_busy), 20'h0, "busy after capture");
  endtask
  task automatic fetch(input logic [20:0] pc, input logic [1:0] be, input logic [15:0] exp, input string what);
    int i;
    i = 0;
    @(posedge clk);
    f_pc  <= pc;
    f_be  <= be;
    f_req <= 1'b1;
    @(posedge clk);
    f_req <= 1'b0;
    #1;
    while (f_valid !== 1'b1 && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(20'(f_valid), 20'h1, "fetch answered");
    chk(20'(f_data), 20'(exp), what);
  endtask
  task automatic t_regs;
    boot(8'hff);
    rd(4'h0, 8'hf8, "config readback");
    wr(4'h0, 8'h00);
    rd(4'h0, 8'hf8, "config write ignored");
    rd(4'h1, 8'h00, "memctl reset");
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hb0, "memctl mask");
    rd(4'h2, 8'h02, "status idle");
    rd(4'h3, 8'h00, "unmapped read");
    $display("t_regs done");
  endtask
  task automatic t_mc;
    boot(8'hf8);
    fetch(21'h00_0246, 2'h3, 16'h0123 ^ 16'h1234, "flash word");
    fetch(F + 21'h2, 2'h3, 16'h0000, "zero above flash");
    chk(io_free, 20'hfffff, "lines free in mc");
    $display("t_mc done");
  endtask
  task automatic t_ext20;
    boot(8'hc8);
    wr(4'h1, 8'h30);
    fetch(F + 21'h2468, 2'h3, 16'h1234 ^ 16'ha5c3, "shifted word");
    fetch(21'h1f_fffe, 2'h3, 16'h7fff ^ 16'ha5c3, "top of space");
    fetch(21'h00_0010, 2'h3, 16'h0008 ^ 16'h1234, "flash below top");
    fetch(F + 21'h0101, 2'h1, {8'h00, ~(8'h80 ^ 8'hc3)}, "lower lane only");
    chk(io_free, 20'h00000, "all lines owned");
    $display("t_ext20 done");
  endtask
  task automatic t_ext16;
    boot(8'h50);
    wr(4'h1, 8'h20);
    fetch(21'h01_5554, 2'h3, 16'haaaa ^ 16'ha5c3, "unshifted word");
    chk(20'(ad_oe_n), 20'h0, "idle lines held");
    rd(4'h2, 8'h06, "status external");
    wr(4'h1, 8'ha0);
    fetch(21'h01_5554, 2'h3, 16'haaaa ^ 16'ha5c3, "word with release");
    chk(20'(ad_oe_n), 20'h0ffff, "idle lines released");
    chk(20'(ah_oe_n), 20'hf, "freed lines undriven");
    chk(io_free, 20'hf0000, "upper lines free");
    $display("t_ext16 done");
  endtask
  task automatic t_narrow;
    boot(8'he0);
    fetch(21'h01_0ace, 2'h3, {4'h0, 12'h567 ^ 12'h5c3}, "12-bit address");
    boot(8'h88);
    fetch(F + 21'h0246, 2'h3, {~(8'h23 ^ 8'hc3), 8'h23 ^ 8'hc3}, "byte pair");
    $display("t_narrow done");
  endtask
  task automatic results;
    $display("%0d checks, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_regs;
    t_mc;
    t_ext20;
    t_ext16;
    t_narrow;
    results;
  end
  initial begin
    #200000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end
endmodule
bind epbc_top epbc_props #(.FLASH_BYTES(FLASH_BYTES)) epbc_props_i (
  .CLK, .RST_N, .CFG_STRAP, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FETCH_REQ, .FETCH_PC,
  .FETCH_BYTE_EN, .FETCH_BUSY, .FETCH_VALID, .FETCH_DATA, .FLASH_RD, .FLASH_ADDR, .AD_O, .AD_OE_N, .AH_O,
  .AH_OE_N, .ALE, .OE_N, .BYTE_ADDR_LSB, .UPPER_BYTE_SEL_N, .LOWER_BYTE_SEL_N, .LINE_IO_FREE);
`default_nettype wire
